// ===== design/hpp_params.svh
/*
  Constants for the handshaked parallel port: lane geometry, counter widths,
  reset levels of the handshake outputs and the default pattern rate.
  Assumes inclusion by name from the package and from hpp_port.
*/
`ifndef HPP_PARAMS_SVH
`define HPP_PARAMS_SVH

`define HPP_NPORTS    4
`define HPP_LANE_W    8
`define HPP_WORD_W    32
`define HPP_CNT_W     16
`define HPP_TOTAL_W   18
`define HPP_IDX_W     2
`define HPP_BUF_DEPTH 2
`define HPP_DIR_IN    1'b1
`define HPP_RATE_DEF  16'h0010
`define HPP_DATA_DEF  32'h00000000
`define HPP_ACK_IDLE  2'h0
`define HPP_ILF_IDLE  4'h0
`define HPP_OPF_IDLE  4'hF

`endif

// ===== design/hpp_pkg.sv
/*
  Types for the handshaked parallel port: styles, modes, controller states
  and the configuration record. Assumes the params header is on the path.
*/
`include "hpp_params.svh"

package hpp_pkg;

  typedef enum logic [0:0] {
    HPP_STY_REQACK = 1'b0,
    HPP_STY_STROBE = 1'b1
  } hpp_style_e;

  typedef enum logic [1:0] {
    HPP_MD_HSK     = 2'b00,
    HPP_MD_BURST   = 2'b01,
    HPP_MD_PATTERN = 2'b10
  } hpp_mode_e;

  typedef enum logic [1:0] {
    HPP_ST_IDLE = 2'b00,
    HPP_ST_RUN  = 2'b01,
    HPP_ST_HOLD = 2'b10
  } hpp_state_e;

  typedef struct packed {
    hpp_style_e                 style;
    hpp_mode_e                  mode;
    logic                       dir;
    logic                       buffered;
    logic [`HPP_NPORTS-1:0]     ports;
    logic [`HPP_IDX_W-1:0]      last;
    logic [`HPP_CNT_W-1:0]      count;
    logic [`HPP_CNT_W-1:0]      rate;
  } hpp_cfg_s;

endpackage : hpp_pkg

// ===== design/hpp_fifo.sv
/*
  Small first-in first-out buffer with valid/ready on both sides.
  Assumes one clock; flush empties it in one cycle.
*/
`timescale 1ns/1ps

module hpp_fifo
  import hpp_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 2
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          flush,
  // fill side
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  // drain side
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  wire logic          out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   cnt;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  wire [AW-1:0] next_wr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;

  assign in_ready  = (cnt != FULL);
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end
    else if (flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= next_wr;
      if (pop)
        rd_ptr <= next_rd;
      if (push && !pop)
        cnt <= cnt + 1'b1;
      else if (pop && !push)
        cnt <= cnt - 1'b1;
    end
  end

endmodule : hpp_fifo

// ===== design/hpp_port.sv
/*
  Handshaked parallel port controller: request/acknowledge style with
  burst and pattern modes, and strobe style with latched and pending flags.
  Assumes pin inputs synchronous to sys_clk; pin tristating done outside.
*/
`timescale 1ns/1ps
`include "hpp_params.svh"

module hpp_port
  import hpp_pkg::*;
#(
  parameter int NPORTS = `HPP_NPORTS,
  parameter int LANE_W = `HPP_LANE_W,
  parameter int DEPTH  = `HPP_BUF_DEPTH
)(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // configuration and control
  input  wire logic                     cfg_load,
  input  wire hpp_cfg_s                 cfg_in,
  input  wire logic                     start,
  // status
  output logic                          busy,
  output logic                          done,
  output logic                          cfg_err,
  output logic [`HPP_CNT_W-1:0]         xfer_count,
  output logic [`HPP_TOTAL_W-1:0]       word_total,
  // user read stream
  output logic [NPORTS*LANE_W-1:0]      rx_data,
  output logic                          rx_valid,
  input  wire logic                     rx_ready,
  // user write stream
  input  wire logic [NPORTS*LANE_W-1:0] tx_data,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  // port data pins
  input  wire logic [NPORTS*LANE_W-1:0] pin_in,
  output logic [NPORTS*LANE_W-1:0]      pin_out,
  output logic [NPORTS*LANE_W-1:0]      pin_oe,
  // request/acknowledge line sets
  input  wire logic [1:0]               req_in,
  output logic [1:0]                    ack_out,
  output logic [1:0]                    pclk_out,
  // strobe style lines, one per port
  input  wire logic [NPORTS-1:0]        input_load_pulse_n,
  output logic [NPORTS-1:0]             input_latched_flag,
  output logic [NPORTS-1:0]             output_pending_flag_n,
  input  wire logic [NPORTS-1:0]        ack_in_n
);

  localparam int WW = NPORTS * LANE_W;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  hpp_cfg_s   cfg;
  hpp_state_e state;
  hpp_state_e next_state;

  logic [WW-1:0]            cap;
  logic                     req_q;
  logic                     stb_q;
  logic                     ackn_q;
  logic                     pclk_q;
  logic                     pending;
  logic [`HPP_CNT_W-1:0]    div;

  wire [WW-1:0]             lane_mask;
  wire [WW-1:0]             in_mask;
  wire [`HPP_TOTAL_W-1:0]   n_in;

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++)
    begin : g_lane
      // every port of the group shares the one handshake event
      assign lane_mask[p*LANE_W +: LANE_W] = {LANE_W{cfg.ports[p]}};
      assign in_mask[p*LANE_W +: LANE_W]   = {LANE_W{cfg_in.ports[p]}};
    end
  endgenerate

  // three-port groups have no lane layout and are refused
  assign n_in = `HPP_TOTAL_W'(cfg_in.ports[0]) + `HPP_TOTAL_W'(cfg_in.ports[1])
              + `HPP_TOTAL_W'(cfg_in.ports[2]) + `HPP_TOTAL_W'(cfg_in.ports[3]);
  wire grp_ok   = ((n_in == 1) && !cfg_in.buffered) || (n_in == 2)
               || (n_in == 4);
  wire last_ok  = cfg_in.ports[cfg_in.last] || (cfg_in.style == HPP_STY_REQACK);
  wire next_err = !(grp_ok && last_ok);

  wire [`HPP_TOTAL_W-1:0] next_total = `HPP_TOTAL_W'(cfg_in.count) * n_in;

  // line set chosen from port membership alone
  wire hs_set = ~(cfg.ports[0] | cfg.ports[1]);
  wire [NPORTS-1:0] last_oh = NPORTS'(1) << cfg.last;

  wire is_in     = (cfg.dir == `HPP_DIR_IN);
  wire strobe    = (cfg.style == HPP_STY_STROBE);
  wire running   = (state == HPP_ST_RUN);
  wire holding   = (state == HPP_ST_HOLD);
  wire is_pat    = (cfg.mode == HPP_MD_PATTERN);
  wire is_burst  = (cfg.mode == HPP_MD_BURST);

  // ---------------------------------------------------------------
  // handshake event detection
  // ---------------------------------------------------------------
  wire req_sel  = req_in[hs_set];
  wire stb_sel  = input_load_pulse_n[cfg.last];
  wire ackn_sel = ack_in_n[cfg.last];
  wire req_rise = req_sel & ~req_q;
  wire stb_rise = stb_sel & ~stb_q;
  wire ack_fall = ~ackn_sel & ackn_q;

  // internal pacing: one tick every rate+1 cycles
  wire tick      = running & (div == cfg.rate);
  wire next_pclk = (running & is_burst & tick) ? ~pclk_q : pclk_q;
  wire burst_ev  = tick & ~pclk_q & req_sel;

  wire ra_ev = is_pat ? tick : (is_burst ? burst_ev : req_rise);
  wire ev    = running & (strobe ? (is_in & stb_rise) : ra_ev);

  // ---------------------------------------------------------------
  // buffers
  // ---------------------------------------------------------------
  wire          rx_in_ready;
  wire          tx_out_valid;
  wire [WW-1:0] tx_out_data;

  // one event waits here while the buffer is stalled; further events in that time merge into the one pending bit
  wire serve_rx    = running & is_in & pending & rx_in_ready;
  wire serve_tx_ra = running & ~is_in & ~strobe & pending & tx_out_valid;
  wire serve_tx_st = running & ~is_in & strobe & tx_out_valid;
  wire pop_tx      = serve_tx_ra | serve_tx_st;
  wire rx_fire     = rx_valid & rx_ready;

  wire [WW-1:0] push_data = strobe ? cap : (pin_in & lane_mask);

  hpp_fifo #(
    .W     (WW),
    .DEPTH (DEPTH)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (cfg_load),
    .in_valid  (serve_rx),
    .in_data   (push_data),
    .in_ready  (rx_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  hpp_fifo #(
    .W     (WW),
    .DEPTH (DEPTH)
  ) u_tx_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (cfg_load),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (tx_out_valid),
    .out_data  (tx_out_data),
    .out_ready (pop_tx)
  );

  // ---------------------------------------------------------------
  // transfer counting and sequencing
  // ---------------------------------------------------------------
  wire xfer_inc = serve_rx | serve_tx_ra | (holding & ack_fall);
  wire [`HPP_CNT_W-1:0] next_xfer = xfer_count + 1'b1;
  wire fin = xfer_inc & (next_xfer >= cfg.count);
  wire next_pending = ev | (pending & ~(serve_rx | serve_tx_ra));

  always_comb
  begin
    next_state = state;
    case (state)
      HPP_ST_IDLE:
        if (start && !cfg_err)
          next_state = HPP_ST_RUN;
      HPP_ST_RUN:
        if (serve_tx_st)
          next_state = HPP_ST_HOLD;
        else if (fin)
          next_state = HPP_ST_IDLE;
      HPP_ST_HOLD:
        if (ack_fall)
          next_state = fin ? HPP_ST_IDLE : HPP_ST_RUN;
      default:
        next_state = HPP_ST_IDLE;
    endcase
    if (cfg_load)
      next_state = HPP_ST_IDLE;
  end

  // answer pulse on the chosen set only, never in pattern mode
  wire       ack_go   = (serve_rx | serve_tx_ra) & ~strobe & ~is_pat;
  wire [1:0] set_oh   = hs_set ? 2'b10 : 2'b01;
  wire [1:0] next_ack = ack_go ? set_oh : `HPP_ACK_IDLE;
  wire [1:0] next_pco = (running & is_burst & next_pclk) ? set_oh : 2'b00;

  // latched flag stays up until the user drains a word; a new capture wins
  wire ilf_keep = serve_rx | (|input_latched_flag & ~rx_fire);
  wire [NPORTS-1:0] next_ilf = (strobe & is_in & ilf_keep) ? last_oh
                             : `HPP_ILF_IDLE;
  wire opf_on = serve_tx_st | (holding & ~ack_fall);
  wire [NPORTS-1:0] next_opf_n = opf_on ? ~last_oh : `HPP_OPF_IDLE;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg     <= '{style: HPP_STY_REQACK, mode: HPP_MD_HSK, dir: `HPP_DIR_IN,
                   buffered: 1'b0, ports: '0, last: '0, count: '0,
                   rate: `HPP_RATE_DEF};
      cfg_err    <= 1'b1;
      word_total <= '0;
      state      <= HPP_ST_IDLE;
      xfer_count <= '0;
      pending    <= 1'b0;
      div        <= '0;
      pclk_q     <= 1'b0;
    end
    else
    begin
      if (cfg_load)
      begin
        cfg        <= cfg_in;
        cfg_err    <= next_err;
        word_total <= next_total;
      end
      state      <= next_state;
      pending    <= (cfg_load || !running) ? 1'b0 : next_pending;
      div        <= (tick || !running) ? '0 : div + 1'b1;
      pclk_q     <= running ? next_pclk : 1'b0;
      if (cfg_load || (state == HPP_ST_IDLE && start))
        xfer_count <= '0;
      else if (xfer_inc)
        xfer_count <= next_xfer;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_q  <= 1'b0;
      stb_q  <= 1'b1;
      ackn_q <= 1'b1;
      cap    <= '0;
    end
    else
    begin
      req_q  <= req_sel;
      stb_q  <= stb_sel;
      ackn_q <= ackn_sel;
      if (!stb_sel)
        cap <= pin_in & lane_mask;
    end
  end

  // outputs come back to their idle levels on reset and on every reconfigure, except pin_oe, which a reconfigure sets to the lanes of an accepted output group
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_out               <= `HPP_DATA_DEF;
      pin_oe                <= '0;
      ack_out               <= `HPP_ACK_IDLE;
      pclk_out              <= 2'b00;
      input_latched_flag    <= `HPP_ILF_IDLE;
      output_pending_flag_n <= `HPP_OPF_IDLE;
      busy                  <= 1'b0;
      done                  <= 1'b0;
    end
    else if (cfg_load)
    begin
      pin_out               <= `HPP_DATA_DEF;
      pin_oe                <= (cfg_in.dir == `HPP_DIR_IN || next_err) ? '0 : in_mask;
      ack_out               <= `HPP_ACK_IDLE;
      pclk_out              <= 2'b00;
      input_latched_flag    <= `HPP_ILF_IDLE;
      output_pending_flag_n <= `HPP_OPF_IDLE;
      busy                  <= 1'b0;
      done                  <= 1'b0;
    end
    else
    begin
      if (pop_tx)
        pin_out <= tx_out_data & lane_mask;
      ack_out               <= next_ack;
      pclk_out              <= next_pco;
      input_latched_flag    <= next_ilf;
      output_pending_flag_n <= next_opf_n;
      busy                  <= (next_state != HPP_ST_IDLE);
      done                  <= fin;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_served;
    (serve_rx || serve_tx_ra) && !strobe && !is_pat && !cfg_load;
  endsequence

  sequence s_ack_pulse;
    ##1 (ack_out == $past(set_oh)) ##1 (ack_out == 2'b00);
  endsequence

  a_ack_one_pulse: assert property (s_served |-> s_ack_pulse)
    else $error("answer pulse missing or too long");
  a_pattern_quiet: assert property (
    ack_out != 2'b00 |-> $past(cfg.mode) != HPP_MD_PATTERN)
    else $error("answer pulse in pattern mode");
  a_set_choice: assert property (
    ack_out[1] |-> !$past(cfg.ports[0]) && !$past(cfg.ports[1]))
    else $error("second set used with low port grouped");
  a_flag_taken: assert property (
    serve_rx && strobe && !cfg_load |=> input_latched_flag == $past(last_oh))
    else $error("latched flag not raised after capture");
  a_flag_input_only: assert property (
    input_latched_flag != 4'h0 |-> $past(is_in) && $past(strobe))
    else $error("latched flag outside strobe input");
  a_pending_held: assert property (
    holding |-> output_pending_flag_n == ~last_oh)
    else $error("pending flag not low while presented");
  a_cfg_defaults: assert property (
    cfg_load |=> pin_out == 32'h0 && ack_out == 2'b00 && input_latched_flag == 4'h0
             && output_pending_flag_n == 4'hF && state == HPP_ST_IDLE)
    else $error("outputs not at default after configure");
  a_input_no_drive: assert property (
    $past(cfg_load) && $past(cfg_in.dir) == `HPP_DIR_IN |-> pin_oe == '0)
    else $error("input group drives pins");
  a_word_total: assert property (
    cfg_load |=> word_total == $past(next_total) && cfg_err == $past(next_err))
    else $error("word total or group check wrong");
  a_group_rule: assert property (
    cfg_load && cfg_in.buffered && n_in == 1 |=> cfg_err ##1 (!start || state == HPP_ST_IDLE))
    else $error("single buffered port accepted");

endmodule : hpp_port

// ===== dv/hpp_partner.sv
/*
  Instrument model for the handshaked parallel port: request/acknowledge
  words, strobe-style loads and strobe-style output answers.
  Assumes the bench calls its tasks between falling edges of sys_clk.
*/
`timescale 1ns/1ps

module hpp_partner (
  // clock
  input  wire logic        sys_clk,
  // device side lines
  input  wire logic [31:0] pin_out,
  input  wire logic [1:0]  ack_out,
  input  wire logic [3:0]  output_pending_flag_n,
  input  wire logic [1:0]  olast,
  // instrument drives
  output logic [31:0]      pin_in,
  output logic [1:0]       req_in,
  output logic [3:0]       input_load_pulse_n,
  output logic [3:0]       ack_in_n,
  output logic             got_valid,
  output logic [31:0]      got_data
);
  initial
  begin
    pin_in = '0;
    req_in = '0;
    input_load_pulse_n = 4'hF;
    ack_in_n = 4'hF;
    got_valid = 1'b0;
    got_data = '0;
  end

  task automatic wait_ack(input int s);
    for (int i = 0; i < 200 && ack_out[s] !== 1'b1; i++) @(negedge sys_clk);
  endtask : wait_ack

  // released data lines show the inverse so stale values never match
  task automatic send_req(input int s, input logic [31:0] d);
    @(negedge sys_clk);
    pin_in = d;
    req_in[s] = 1'b1;
    @(negedge sys_clk);
    wait_ack(s);
    req_in[s] = 1'b0;
    pin_in = ~d;
    @(negedge sys_clk);
  endtask : send_req

  task automatic fetch_req(input int s);
    @(negedge sys_clk);
    req_in[s] = 1'b1;
    @(negedge sys_clk);
    wait_ack(s);
    got_data = pin_out;
    got_valid = 1'b1;
    req_in[s] = 1'b0;
    @(negedge sys_clk);
    got_valid = 1'b0;
  endtask : fetch_req

  task automatic hold(input logic [1:0] r, input logic [31:0] d);
    @(negedge sys_clk);
    req_in = r;
    pin_in = d;
  endtask : hold

  // all load lines are wired together for a grouped input
  task automatic strobe(input logic [31:0] d);
    @(negedge sys_clk);
    pin_in = d;
    input_load_pulse_n = 4'h0;
    repeat (2) @(negedge sys_clk);
    input_load_pulse_n = 4'hF;
    pin_in = ~d;
  endtask : strobe

  // a slow instrument: two cycles before it answers a pending word
  initial forever
  begin
    @(negedge sys_clk);
    if (output_pending_flag_n[olast] === 1'b0)
    begin
      repeat (2) @(negedge sys_clk);
      got_data = pin_out;
      got_valid = 1'b1;
      ack_in_n[olast] = 1'b0;
      @(negedge sys_clk);
      got_valid = 1'b0;
      ack_in_n = 4'hF;
      while (output_pending_flag_n[olast] === 1'b0) @(negedge sys_clk);
    end
  end
endmodule : hpp_partner

// ===== dv/hpp_port_tb.sv
/*
  Self-checking bench for hpp_port: the bench queues expected words,
  a monitor compares every word that the user side or the instrument model receives.
  Assumes the design files and the package are compiled first.
*/
`timescale 1ns/1ps

module hpp_port_tb;
  import hpp_pkg::*;
  logic sys_clk, rst, cfg_load, start, rx_ready, tx_valid;
  logic busy, done, cfg_err, rx_valid, tx_ready, got_valid;
  logic ack_seen, pclk_seen, done_seen;
  hpp_cfg_s cfg_in;
  logic [15:0] xfer_count;
  logic [17:0] word_total;
  logic [31:0] rx_data, tx_data, pin_in, pin_out, pin_oe, got_data, d, m;
  logic [1:0]  req_in, ack_out, pclk_out, olast;
  logic [3:0]  input_load_pulse_n, input_latched_flag, output_pending_flag_n, ack_in_n;
  logic [3:0]  bad_pm [3] = '{4'h7, 4'h1, 4'h3};
  logic [3:0]  rq_pm [3] = '{4'hC, 4'h5, 4'hF};
  logic [31:0] exp_q [$];
  int mismatches, comparisons, seed, j, k, s;

  hpp_port dut (.sys_clk(sys_clk), .rst(rst), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .start(start), .busy(busy), .done(done), .cfg_err(cfg_err), .xfer_count(xfer_count),
    .word_total(word_total), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .req_in(req_in), .ack_out(ack_out),
    .pclk_out(pclk_out), .input_load_pulse_n(input_load_pulse_n),
    .input_latched_flag(input_latched_flag), .output_pending_flag_n(output_pending_flag_n),
    .ack_in_n(ack_in_n));

  hpp_partner p (.sys_clk(sys_clk), .pin_out(pin_out), .ack_out(ack_out),
    .output_pending_flag_n(output_pending_flag_n), .olast(olast), .pin_in(pin_in),
    .req_in(req_in), .input_load_pulse_n(input_load_pulse_n), .ack_in_n(ack_in_n),
    .got_valid(got_valid), .got_data(got_data));

  // ----------------------------------------------------------------
  // compare, drive and scoreboard tasks
  // ----------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected word at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_stat(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected status at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_stat

  task automatic final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  function automatic logic [31:0] lanes(input logic [3:0] pm);
    lanes = {{8{pm[3]}}, {8{pm[2]}}, {8{pm[1]}}, {8{pm[0]}}};
  endfunction : lanes

  task automatic take(input logic [31:0] w);
    if (exp_q.size() == 0)
      cmp_word(w, ~w);
    else
      cmp_word(w, exp_q.pop_front());
  endtask : take

  task automatic setup(input logic sty, input logic [1:0] md, input logic dr,
                       input logic bf, input logic [3:0] pm, input logic [1:0] ls,
                       input logic [15:0] n);
    logic err;
    int c;
    c = $countones(pm);
    err = !(c == 1 || c == 2 || c == 4) || (c == 1 && bf) || (sty && !pm[ls]);
    @(negedge sys_clk);
    cfg_in = '{hpp_style_e'(sty), hpp_mode_e'(md), dr, bf, pm, ls, n, 16'h0003};
    cfg_load = 1'b1;
    olast = ls;
    done_seen = 1'b0;
    @(negedge sys_clk);
    cfg_load = 1'b0;
    @(negedge sys_clk);
    cmp_stat(cfg_err, err);
    if (!err) cmp_stat(word_total, n * c);
    cmp_stat(pin_oe, dr ? 32'h0 : lanes(pm));
    cmp_stat({ack_out, input_latched_flag, output_pending_flag_n}, 10'h00F);
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    @(negedge sys_clk);
    cmp_stat(busy, !err);
  endtask : setup

  task automatic put_tx(input logic [31:0] w);
    @(negedge sys_clk);
    tx_data = w;
    tx_valid = 1'b1;
    for (int i = 0; i < 200; i++)
    begin
      @(posedge sys_clk);
      if (tx_ready === 1'b1) break;
    end
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask : put_tx

  task automatic finish_run(input logic [15:0] n);
    for (int i = 0; i < 2000 && done_seen !== 1'b1; i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    cmp_stat({done_seen, busy, xfer_count}, {1'b1, 1'b0, n});
    cmp_stat(exp_q.size(), 0);
  endtask : finish_run

  always @(posedge sys_clk)
  begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) take(rx_data);
    if (got_valid === 1'b1) take(got_data);
    if (ack_out !== 2'h0) ack_seen = 1'b1;
    if (pclk_out !== 2'h0) pclk_seen = 1'b1;
    if (done === 1'b1) done_seen = 1'b1;
  end

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end

  initial
  begin
    seed = 32'hcee1;
    {rst, cfg_load, start, rx_ready, tx_valid, tx_data, cfg_in, olast} = '0;
    rst = 1'b1;
    {mismatches, comparisons, ack_seen, pclk_seen, done_seen} = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    rx_ready = 1'b1;
    @(negedge sys_clk);
    cmp_stat({cfg_err, busy, ack_out, input_latched_flag, output_pending_flag_n}, 12'h80F);
    for (j = 0; j < 3; j++) setup(j == 2, 2'h0, 1'b1, j == 1, bad_pm[j], 2'h2, 16'h1);
    foreach (rq_pm[k])
    begin
      m = lanes(rq_pm[k]);
      s = (rq_pm[k][0] | rq_pm[k][1]) ? 0 : 1;
      setup(1'b0, 2'h0, 1'b1, 1'b1, rq_pm[k], 2'h0, 16'h3);
      rx_ready = (k != 0);
      fork
        for (j = 0; j < 3; j++)
        begin
          d = $random(seed);
          exp_q.push_back(d & m);
          p.send_req(s, d);
        end
        begin
          repeat (40) @(negedge sys_clk);
          if (k == 0) cmp_stat({rx_valid, xfer_count}, 17'h10002);
          rx_ready = 1'b1;
        end
      join
      finish_run(16'h3);
    end
    setup(1'b0, 2'h0, 1'b0, 1'b0, 4'h2, 2'h0, 16'h3);
    fork
      for (j = 0; j < 3; j++)
      begin
        d = $random(seed) & 32'h0000FF00;
        exp_q.push_back(d);
        put_tx(d);
      end
      begin
        repeat (20) @(negedge sys_clk);
        cmp_stat(tx_ready, 1'b0);
        repeat (3) p.fetch_req(0);
      end
    join
    finish_run(16'h3);
    d = $random(seed);
    p.hold(2'h0, d);
    ack_seen = 1'b0;
    repeat (2) exp_q.push_back(d & 32'h0000FFFF);
    setup(1'b0, 2'h2, 1'b1, 1'b1, 4'h3, 2'h0, 16'h2);
    finish_run(16'h2);
    cmp_stat(ack_seen, 1'b0);
    p.hold(2'h1, d);
    pclk_seen = 1'b0;
    repeat (3) exp_q.push_back(d);
    setup(1'b0, 2'h1, 1'b1, 1'b1, 4'hF, 2'h0, 16'h3);
    finish_run(16'h3);
    cmp_stat(pclk_seen, 1'b1);
    p.hold(2'h0, ~d);
    for (k = 1; k >= 0; k--)
    begin
      setup(1'b1, 2'h0, 1'b1, 1'b0, 4'h3, k[1:0], 16'h1);
      rx_ready = 1'b0;
      d = $random(seed);
      exp_q.push_back(d & 32'h0000FFFF);
      p.strobe(d);
      for (j = 0; j < 50 && input_latched_flag === 4'h0; j++) @(negedge sys_clk);
      cmp_stat(input_latched_flag, 4'h1 << k);
      rx_ready = 1'b1;
      finish_run(16'h1);
    end
    setup(1'b1, 2'h0, 1'b0, 1'b0, 4'h3, 2'h0, 16'h2);
    for (j = 0; j < 2; j++)
    begin
      d = $random(seed) & 32'h0000FFFF;
      exp_q.push_back(d);
      put_tx(d);
    end
    finish_run(16'h2);
    final_report();
  end
endmodule : hpp_port_tb
